/* rtd_pkg.sv */
package rtd_pkg;
    // widths
    localparam int TIME_W = 32;
    localparam int HOP_W = 5;
    localparam int SHIFT_W = 8;
    // defaults
    localparam logic [TIME_W-1:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [TIME_W-1:0] PERIOD_RST = 32'h0000_0000;
    localparam int MAX_HOPS = 16;
    // with one hop the one-way split is a halving; a chain halves the round trip less both through-delay sums
    localparam int HALF_SHIFT = 1;
    // how long a measurement may wait for its frame markers before it is given up, in ns, then in cycles
    localparam int TIMEOUT_NS = 10000000;
    localparam int CLK_NS = 20;
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CALC, S_SUM} rtd_state_t;
endpackage

/* rtd_hop_if.sv */
`timescale 1ns/1ps
interface rtd_hop_if #(parameter int TIME_W = 32, parameter int SHIFT_W = 8);
    // one hop's report, applied one hop per clock cycle
    logic valid;
    logic [SHIFT_W-1:0] shift;
    logic [TIME_W-1:0] dl_delay;
    logic [TIME_W-1:0] ul_delay;
    logic clear;
    logic [TIME_W-1:0] shift_sum;
    logic [TIME_W-1:0] dl_sum;
    logic [TIME_W-1:0] ul_sum;
    modport src (output valid, shift, dl_delay, ul_delay, clear);
    modport acc (input valid, shift, dl_delay, ul_delay, clear,
        output shift_sum, dl_sum, ul_sum);
endinterface

/* rtd_hop_acc.sv */
`timescale 1ns/1ps
module rtd_hop_acc
    import rtd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // hop reports
    rtd_hop_if.acc hop
);
    typedef struct packed {
        logic [TIME_W-1:0] shift_sum;
        logic [TIME_W-1:0] dl_sum;
        logic [TIME_W-1:0] ul_sum;
    } acc_t;
    acc_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (hop.clear) begin
            s_d = '0;
        end else if (hop.valid) begin
            // sum the frame shifts of networking units [RQ8]
            s_d.shift_sum = s_q.shift_sum + TIME_W'(hop.shift);
            s_d.dl_sum = s_q.dl_sum + hop.dl_delay; // [RQ12]
            s_d.ul_sum = s_q.ul_sum + hop.ul_delay; // [RQ12]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hop.shift_sum = s_q.shift_sum;
    assign hop.dl_sum = s_q.dl_sum;
    assign hop.ul_sum = s_q.ul_sum;

    property p_hop_sum;
        @(posedge ref_clk) disable iff (!rst_b)
        hop.valid && !hop.clear |=>
            hop.shift_sum == $past(hop.shift_sum) + TIME_W'($past(hop.shift));
    endproperty
    a_hop_sum: assert property (p_hop_sum) // [RQ8]
        else $error("hop shift sum wrong");
endmodule // rtd_hop_acc

/* rtd_calib.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Time runs from the downlink frame start out to the uplink start in.
// RQ2: The round trip is the loop count minus a fixed offset.
// RQ3: With one hop each one-way delay is half of the round trip.
// RQ4: Offsets of internal measuring points are folded into the offset.
// RQ5: Overall delays add the remote internal delays to one-way delays.
// RQ6: In TDD a later valid sample may mark the frame, plus its known lead.
// RQ7: A chain's loop time adds total frame shift times the frame period.
// RQ8: Units 1 to M-1 report uplink frame shifts, which are summed.
// RQ9: Networking units report their downlink and uplink through-delays.
// RQ10: Downlink through-delay is fixed; uplink through-delay is measured.
// RQ11: In a chain the one-way split is not a plain halving.
// RQ12: Chain one-way delays use the round trip and all through-delays.
// RQ13: Each way is half of round trip less both sums, plus its own sum.
module rtd_calib
    import rtd_pkg::*;
#(
    parameter int MAX_HOP = MAX_HOPS,
    parameter int TIMEOUT = TIMEOUT_CYC
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // frame markers, same clock domain
    input wire logic dl_frame_out,
    input wire logic ul_frame_in,
    // configuration
    input wire logic start,
    input wire logic [HOP_W-1:0] hop_count,
    input wire logic [TIME_W-1:0] fixed_offset,
    input wire logic [TIME_W-1:0] sample_lead,
    input wire logic [TIME_W-1:0] basic_frame_period,
    input wire logic [TIME_W-1:0] remote_tx_internal_delay,
    input wire logic [TIME_W-1:0] remote_rx_internal_delay,
    // hop reports, one per cycle
    input wire logic hop_valid,
    input wire logic [SHIFT_W-1:0] hop_shift,
    input wire logic [TIME_W-1:0] hop_down_through_delay,
    input wire logic [TIME_W-1:0] hop_up_through_delay,
    // results
    output logic busy,
    output logic done,
    output logic timeout,
    output logic [TIME_W-1:0] loop_frame_offset,
    output logic [TIME_W-1:0] round_trip,
    output logic [TIME_W-1:0] downlink_link_delay,
    output logic [TIME_W-1:0] uplink_link_delay,
    output logic [TIME_W-1:0] overall_dl_delay,
    output logic [TIME_W-1:0] overall_ul_delay
);
    if (MAX_HOP < 1 || MAX_HOP >= (1 << HOP_W) || TIMEOUT < 1) begin : g_bad
        $error("rtd_calib: bad parameters");
    end

    typedef struct packed {
        rtd_state_t st;
        logic [TIME_W-1:0] cnt;
        logic [TIME_W-1:0] wcnt;
        logic [HOP_W-1:0] hops;
        logic [HOP_W-1:0] rpt;
        logic busy;
        logic done;
        logic timeout;
        logic [TIME_W-1:0] loop;
        logic [TIME_W-1:0] rt;
        logic [TIME_W-1:0] dl;
        logic [TIME_W-1:0] ul;
        logic [TIME_W-1:0] odl;
        logic [TIME_W-1:0] oul;
    } calib_t;
    calib_t s_q, s_d;

    rtd_hop_if #(.TIME_W(TIME_W), .SHIFT_W(SHIFT_W)) hop ();
    rtd_hop_acc u_acc (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .hop(hop)
    );
    logic need_hops;
    assign need_hops = s_q.hops > HOP_W'(1);
    assign hop.clear = start && s_q.st == S_IDLE;
    // only units 1..M-1 count [RQ8]
    assign hop.valid = hop_valid && s_q.busy && need_hops &&
        (s_q.rpt < s_q.hops - HOP_W'(1));
    assign hop.shift = hop_shift;
    assign hop.dl_delay = hop_down_through_delay; // [RQ9]
    assign hop.ul_delay = hop_up_through_delay; // [RQ10]

    logic [TIME_W-1:0] loop_full, rt_v, asym, half;
    always_comb begin
        // chain loop = first hop + shift * period [RQ7]
        loop_full = s_q.loop
            + TIME_W'(hop.shift_sum * basic_frame_period);
        rt_v = loop_full - fixed_offset; // [RQ2] [RQ4]
        asym = hop.dl_sum + hop.ul_sum;
        half = (rt_v - asym) >> HALF_SHIFT; // [RQ13] [RQ11]
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // reports are counted whenever they are taken [RQ8]
        if (hop.valid) begin
            s_d.rpt = s_q.rpt + HOP_W'(1);
        end
        case (s_q.st)
            S_IDLE: begin
                if (start) begin
                    s_d.st = S_WAIT;
                    s_d.cnt = '0;
                    s_d.wcnt = '0;
                    s_d.rpt = '0;
                    s_d.busy = 1'b1;
                    s_d.timeout = 1'b0;
                    if (hop_count == '0) begin
                        s_d.hops = HOP_W'(1);
                    end else if (hop_count > HOP_W'(MAX_HOP)) begin
                        s_d.hops = HOP_W'(MAX_HOP);
                    end else begin
                        s_d.hops = hop_count;
                    end
                end
            end
            S_WAIT: begin
                // waiting is bounded even if no downlink marker leaves
                s_d.wcnt = s_q.wcnt + TIME_W'(1);
                if (dl_frame_out && s_q.cnt == '0) begin
                    s_d.cnt = TIME_W'(1);
                end else if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt + TIME_W'(1);
                end
                if (s_q.cnt != '0 && ul_frame_in) begin
                    // loop count, plus lead of a later marker sample
                    s_d.loop = s_q.cnt + sample_lead; // [RQ1] [RQ6]
                    s_d.st = S_SUM;
                end else if (s_q.wcnt >= TIME_W'(TIMEOUT)) begin
                    s_d.timeout = 1'b1;
                    s_d.busy = 1'b0;
                    s_d.st = S_IDLE;
                end
            end
            S_SUM: begin
                if (!need_hops || s_q.rpt >= s_q.hops - HOP_W'(1)) begin
                    s_d.st = S_CALC;
                end
            end
            S_CALC: begin
                s_d.rt = rt_v;
                if (!need_hops) begin
                    s_d.dl = rt_v >> HALF_SHIFT; // [RQ3]
                    s_d.ul = rt_v >> HALF_SHIFT; // [RQ3]
                end else begin
                    s_d.dl = half + hop.dl_sum; // [RQ12] [RQ13]
                    s_d.ul = half + hop.ul_sum; // [RQ12] [RQ13]
                end
                s_d.loop = loop_full;
                s_d.odl = s_d.dl + remote_tx_internal_delay; // [RQ5]
                s_d.oul = s_d.ul + remote_rx_internal_delay; // [RQ5]
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = S_IDLE;
            end
            default: s_d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign timeout = s_q.timeout;
    assign loop_frame_offset = s_q.loop;
    assign round_trip = s_q.rt;
    assign downlink_link_delay = s_q.dl;
    assign uplink_link_delay = s_q.ul;
    assign overall_dl_delay = s_q.odl;
    assign overall_ul_delay = s_q.oul;

    // ===================================================
    // checks
    property p_rt;
        @(posedge ref_clk) disable iff (!rst_b)
        done |-> round_trip == loop_frame_offset - $past(fixed_offset);
    endproperty
    a_rt: assert property (p_rt) // [RQ2]
        else $error("round trip not loop minus offset");

    property p_half;
        @(posedge ref_clk) disable iff (!rst_b)
        done && s_q.hops == HOP_W'(1) |->
            downlink_link_delay == (round_trip >> 1) &&
            uplink_link_delay == downlink_link_delay;
    endproperty
    a_half: assert property (p_half) // [RQ3]
        else $error("single hop split not half");

    property p_overall;
        @(posedge ref_clk) disable iff (!rst_b)
        done |-> overall_dl_delay ==
            downlink_link_delay + $past(remote_tx_internal_delay) &&
            overall_ul_delay ==
            uplink_link_delay + $past(remote_rx_internal_delay);
    endproperty
    a_overall: assert property (p_overall) // [RQ5]
        else $error("overall delay wrong");

    property p_sym;
        @(posedge ref_clk) disable iff (!rst_b)
        done && s_q.hops > HOP_W'(1) |->
            downlink_link_delay - hop.dl_sum ==
            uplink_link_delay - hop.ul_sum;
    endproperty
    a_sym: assert property (p_sym) // [RQ13]
        else $error("chain split not symmetric per hop");

    sequence s_meas;
        s_q.st == S_WAIT ##1 s_q.st == S_SUM;
    endsequence
    property p_meas;
        @(posedge ref_clk) disable iff (!rst_b)
        s_meas |-> s_q.loop == $past(s_q.cnt) + $past(sample_lead);
    endproperty
    a_meas: assert property (p_meas) // [RQ1]
        else $error("loop count wrong");

    property p_done_pulse;
        @(posedge ref_clk) disable iff (!rst_b)
        done |=> !done && !busy;
    endproperty
    a_done_pulse: assert property (p_done_pulse) // done lasts one cycle and busy is low after it
        else $error("done not single pulse");

    property p_hopcnt;
        @(posedge ref_clk) disable iff (!rst_b)
        s_q.st == S_SUM |-> s_q.rpt <= s_q.hops;
    endproperty
    a_hopcnt: assert property (p_hopcnt) // [RQ8]
        else $error("too many hop reports");

    property p_loopfull;
        @(posedge ref_clk) disable iff (!rst_b)
        done |-> loop_frame_offset == $past(s_q.loop) +
            TIME_W'(hop.shift_sum * $past(basic_frame_period));
    endproperty
    a_loopfull: assert property (p_loopfull) // [RQ7]
        else $error("chain loop time wrong");
endmodule // rtd_calib

/* rtd_chain_model.sv */
`timescale 1ns/1ps
module rtd_chain_model
    import rtd_pkg::*;
#(
    parameter logic [TIME_W-1:0] DOWN_BASE = 32'h0000_0040
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link setup
    input wire logic dl_frame_out,
    input wire logic [HOP_W-1:0] hops,
    input wire logic [TIME_W-1:0] loop_n,
    // far side answers
    output logic ul_frame_in,
    output logic hop_valid,
    output logic [SHIFT_W-1:0] hop_shift,
    output logic [TIME_W-1:0] hop_down_through_delay,
    output logic [TIME_W-1:0] hop_up_through_delay
);
    int cnt;
    always @(posedge ref_clk) begin
        // count runs only from a downlink marker to its uplink answer
        if (!rst_b) begin
            cnt <= 0;
        end else if (dl_frame_out) begin
            cnt <= 1;
        end else if (cnt > 0 && cnt < int'(loop_n)) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
        ul_frame_in <= rst_b && cnt > 0 && cnt == int'(loop_n) - 1;
        if (!rst_b) begin
            hop_valid <= 1'b0;
            hop_shift <= '0;
            hop_down_through_delay <= '0;
            hop_up_through_delay <= '0;
        end else if (cnt > 0 && cnt < int'(hops)) begin
            hop_valid <= 1'b1;
            hop_shift <= SHIFT_W'(cnt);
            hop_down_through_delay <= DOWN_BASE + TIME_W'(cnt);
            hop_up_through_delay <= loop_n + TIME_W'(cnt);
        end else begin
            // released report lines show the inverse
            hop_valid <= 1'b0;
            hop_shift <= ~hop_shift;
            hop_down_through_delay <= ~hop_down_through_delay;
            hop_up_through_delay <= ~hop_up_through_delay;
        end
    end
endmodule // rtd_chain_model

/* rtd_calib_tb_top.sv */
`timescale 1ns/1ps
module rtd_calib_tb_top;
    import rtd_pkg::*;
    localparam int TMO = 100;
    localparam logic [TIME_W-1:0] DB = 32'h0000_0040;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic dl_frame_out = 1'b0;
    logic start = 1'b0;
    logic [HOP_W-1:0] hop_count = '0;
    logic [TIME_W-1:0] off = '0, lead = '0, per = '0, loop_n = '0;
    logic [TIME_W-1:0] tx_i = 32'h0000_0123, rx_i = 32'h0000_0456;
    logic ul_frame_in, hop_valid, busy, done, timeout;
    logic [SHIFT_W-1:0] sh_w;
    logic [TIME_W-1:0] dn_w, up_w, lfo, rt, dl, ul, odl, oul;
    int fail_count = 0;
    int n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    rtd_calib #(.MAX_HOP(16), .TIMEOUT(TMO)) i_rtd_calib (
        .ref_clk(ref_clk), .rst_b(rst_b), .dl_frame_out(dl_frame_out),
        .ul_frame_in(ul_frame_in), .start(start), .hop_count(hop_count),
        .fixed_offset(off), .sample_lead(lead), .basic_frame_period(per),
        .remote_tx_internal_delay(tx_i), .remote_rx_internal_delay(rx_i),
        .hop_valid(hop_valid), .hop_shift(sh_w),
        .hop_down_through_delay(dn_w), .hop_up_through_delay(up_w),
        .busy(busy), .done(done), .timeout(timeout),
        .loop_frame_offset(lfo), .round_trip(rt),
        .downlink_link_delay(dl), .uplink_link_delay(ul),
        .overall_dl_delay(odl), .overall_ul_delay(oul));
    rtd_chain_model #(.DOWN_BASE(DB)) i_rtd_chain_model (
        .ref_clk(ref_clk), .rst_b(rst_b), .dl_frame_out(dl_frame_out),
        .hops(hop_count), .loop_n(loop_n), .ul_frame_in(ul_frame_in),
        .hop_valid(hop_valid), .hop_shift(sh_w),
        .hop_down_through_delay(dn_w), .hop_up_through_delay(up_w));
    // ==========================================
    // checking and closing
    task automatic check(input logic [TIME_W-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_done(input int lim);
        int k;
        k = 0;
        while (done !== 1'b1 && k < lim) begin
            @(posedge ref_clk);
            #1 k++;
        end
    endtask
    // ==========================================
    // one measurement, expectations from the hop reports
    task automatic measure(input int m, n, ld, of, pr, bit dup);
        logic [TIME_W-1:0] s, ds, us, lp, r, edl, eul;
        int me;
        me = (m == 0) ? 1 : m;
        s = '0;
        ds = '0;
        us = '0;
        for (int i = 1; i < me; i++) begin
            s += i;
            ds += DB + i;
            us += n + i;
        end
        lp = n + ld + s * pr;
        r = lp - of;
        edl = ((r - ds - us) >> 1) + ds;
        eul = ((r - ds - us) >> 1) + us;
        @(posedge ref_clk);
        hop_count <= HOP_W'(m);
        off <= of;
        lead <= ld;
        per <= pr;
        loop_n <= n;
        start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        @(posedge ref_clk);
        #1 check(TIME_W'(busy), 32'h1);
        @(posedge ref_clk);
        dl_frame_out <= 1'b1;
        @(posedge ref_clk) dl_frame_out <= 1'b0;
        if (dup) start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        wait_done(n + 40);
        check(TIME_W'(done), 32'h1);
        check(TIME_W'(busy), 32'h0);
        check(lfo, lp);
        check(rt, r);
        check(dl, edl);
        check(ul, eul);
        check(odl, edl + tx_i);
        check(oul, eul + rx_i);
    endtask
    // ==========================================
    // scenarios
    task automatic t_single_odd();
        measure(8'h01, 8'h26, 8'h00, 8'h05, 8'h00, 1'b0);
    endtask
    task automatic t_zero_hops_tdd();
        measure(8'h00, 8'h1E, 8'h07, 8'h04, 8'h09, 1'b0);
    endtask
    task automatic t_chain_four();
        measure(8'h04, 8'h28, 8'h02, 8'h07, 8'h64, 1'b0);
    endtask
    task automatic t_start_refused();
        measure(8'h02, 8'h19, 8'h00, 8'h03, 8'h32, 1'b1);
    endtask
    task automatic t_timeout();
        int k;
        @(posedge ref_clk) start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        k = 0;
        while (timeout !== 1'b1 && k < TMO + 20) begin
            @(posedge ref_clk);
            #1 k++;
        end
        check(TIME_W'(timeout), 32'h1);
        check(TIME_W'(k > TMO - 5), 32'h1);
        check(TIME_W'(busy), 32'h0);
        @(posedge ref_clk) start <= 1'b1;
        @(posedge ref_clk) start <= 1'b0;
        @(posedge ref_clk);
        #1 check(TIME_W'(timeout), 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_single_odd();
        t_zero_hops_tdd();
        t_chain_four();
        t_start_refused();
        t_timeout();
        complete_run();
    end
    initial begin
        #50us;
        fail_count++;
        complete_run();
    end
endmodule // rtd_calib_tb_top
